// ==== pmr_pkg.sv ====
// constants for the power management register bank
package pmr_pkg;

    // configuration dword addresses and word offsets (byte addresses)
    localparam logic [7:0]  CAP_DW_ADDR        = 8'hA0;
    localparam logic [7:0]  CTL_DW_ADDR        = 8'hA4;
    localparam logic [7:0]  CAP_WORD_OFFSET    = 8'hA2;
    localparam logic [7:0]  CTL_WORD_OFFSET    = 8'hA4;

    // capability word field positions
    localparam int          CAP_D3COLD_BIT     = 15;
    localparam int          CAP_AUX_BIT        = 4;
    localparam int          CAP_CLK_BIT        = 3;

    // capability word constant fields
    localparam logic [3:0]  CAP_WAKE_LOW_MASK  = 4'hF;
    localparam logic        CAP_STATE2_SUP     = 1'h1;
    localparam logic        CAP_STATE1_SUP     = 1'h1;
    localparam logic [2:0]  CAP_RSVD_VAL       = 3'h0;
    localparam logic        CAP_DSI_VAL        = 1'h0;
    localparam logic        CAP_AUX_REQUIRED   = 1'h1;
    localparam logic        CAP_WAKE_NEEDS_CLK = 1'h0;
    localparam logic [2:0]  CAP_VERSION        = 3'h2;
    localparam logic        CAP_D3COLD_RST     = 1'h1;

    // control/status word field positions
    localparam int          CTL_STATUS_BIT     = 15;
    localparam int          CTL_ENABLE_BIT     = 8;
    localparam int          CTL_STATE_LSB      = 0;
    localparam logic [1:0]  CTL_DATA_SCALE     = 2'h0;
    localparam logic [3:0]  CTL_DATA_SELECT    = 4'h0;
    localparam logic [5:0]  CTL_RSVD_VAL       = 6'h00;
    localparam logic [15:0] CTL_RST_VAL        = 16'h0000;

    // power state encodings
    localparam logic [1:0]  PS_D0              = 2'h0;
    localparam logic [1:0]  PS_D1              = 2'h1;
    localparam logic [1:0]  PS_D2              = 2'h2;
    localparam logic [1:0]  PS_D3HOT           = 2'h3;

    // length of the internal function reset after leaving D3hot
    localparam logic [3:0]  FUNC_RST_CYCLES    = 4'h8;

    typedef enum logic [0:0] {PMR_RUN, PMR_FUNC_RST} pmr_state_t;

endpackage : pmr_pkg

// ==== pmr_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pmr_sync #(
    parameter logic RST_VAL = 1'h1
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // pin and synchronised level
    input  wire logic pinIn,
    output var  logic levelOut
);
    logic stage1_r;
    logic stage2_r;
    logic stage3_r;

    // stage1 feeds only stage2; output moves once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_r <= RST_VAL;
            stage2_r <= RST_VAL;
            stage3_r <= RST_VAL;
            levelOut <= RST_VAL;
        end else if (clkEn) begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            if (stage2_r == stage3_r) begin
                levelOut <= stage3_r;
            end
        end
    end
endmodule : pmr_sync
`default_nettype wire

// ==== pmr_wake_ctl.sv ====
// wake status flag, wake enable and wake output
`timescale 1ns/100ps
`default_nettype none
module pmr_wake_ctl (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // event and register writes
    input  wire logic wakeEvent,
    input  wire logic statusClr,
    input  wire logic enableWr,
    input  wire logic enableVal,
    // state
    output var  logic wakeStatusFlag,
    output var  logic wakeEnableBit,
    output var  logic wakeOut_n
);
    logic statusNxt;
    logic enableNxt;

    // set wins over a clear in the same cycle
    assign statusNxt = wakeEvent | (wakeStatusFlag & ~statusClr);
    assign enableNxt = enableWr ? enableVal : wakeEnableBit;

    // only the global reset reaches these flops; bus reset never does
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeStatusFlag <= 1'h0;
            wakeEnableBit  <= 1'h0;
            wakeOut_n      <= 1'h1;
        end else if (clkEn) begin
            wakeStatusFlag <= statusNxt;
            wakeEnableBit  <= enableNxt;
            wakeOut_n      <= ~(statusNxt & enableNxt);
        end
    end
endmodule : pmr_wake_ctl
`default_nettype wire

// ==== pmr_regs.sv ====
// power management capability and control/status register bank
//
// Contract
// - D3cold wake bit writable, resets to one
// - capability bits 14..11 read as ones
// - bits 10 and 9 read as ones
// - bits 8..5 read as zero
// - aux bit reads zero unless bit15 set
// - bit 3 tells bus clock need
// - bits 2..0 read constant 010b
// - writable capability bit set to one by global reset
// - control/status survives internal D3hot reset
// - D3hot-to-D0 resets function, keeps wake context only if wake enable is set
// - wake event sets status regardless of enable
// - write one clears status; zero ignored
// - data scale and select read zero
// - wake driven only while enable set
// - bus reset never clears wake enable
// - control bits 7..2 read zero, ignore writes
// - power state field read and written
`timescale 1ns/100ps
`default_nettype none
module pmr_regs
    import pmr_pkg::*;
(
    // clock, global reset and clock enable
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // bus reset pin, asynchronous to ref_clk
    input  wire logic        busReset_n,
    // configuration access port
    input  wire logic        cfgWrEn,
    input  wire logic        cfgRdEn,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    output var  logic [31:0] cfgRdData,
    output var  logic        cfgRdValid,
    // wake source from the function logic
    input  wire logic        wakeEvent,
    // wake pin and function control
    output var  logic        wakeOut_n,
    output var  logic [1:0]  powerStateField,
    output var  logic        funcReset,
    output var  logic        wakeCtxKeep
);
    import pmr_pkg::*;

    // true when the access address falls inside the given dword
    function automatic logic hitDword(input logic [7:0] addr, input logic [7:0] base);
        hitDword = (addr[7:2] == base[7:2]);
    endfunction : hitDword

    // byte-lane merge for a 16-bit word held in the upper or lower half
    function automatic logic [15:0] laneMerge(input logic [15:0] oldVal,
                                              input logic [15:0] newVal,
                                              input logic [1:0]  lanes);
        laneMerge = oldVal;
        if (lanes[0]) begin
            laneMerge[7:0] = newVal[7:0];
        end
        if (lanes[1]) begin
            laneMerge[15:8] = newVal[15:8];
        end
    endfunction : laneMerge

    // ---------------------------------------------------------------
    // bus reset synchronisation
    // ---------------------------------------------------------------
    logic        busResetSync_n;

    pmr_sync #(
        .RST_VAL (1'h1)
    ) u_bus_reset_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .pinIn    (busReset_n),
        .levelOut (busResetSync_n)
    );

    logic        busRstActive;
    assign busRstActive = ~busResetSync_n;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    logic        capHit;
    logic        ctlHit;
    logic        capWr;
    logic        ctlWr;
    logic        capRd;
    logic        ctlRd;
    logic [15:0] capWrWord;
    logic [15:0] ctlWrWord;
    logic [1:0]  capLanes;
    logic [1:0]  ctlLanes;

    assign capHit    = hitDword(cfgAddr, CAP_DW_ADDR);
    assign ctlHit    = hitDword(cfgAddr, CTL_DW_ADDR);
    assign capWr     = cfgWrEn & capHit & ~busRstActive;
    assign ctlWr     = cfgWrEn & ctlHit & ~busRstActive;
    assign capRd     = cfgRdEn & capHit;
    assign ctlRd     = cfgRdEn & ctlHit;
    // capability word sits in the upper half, control/status in the lower
    assign capWrWord = cfgWrData[31:16];
    assign ctlWrWord = cfgWrData[15:0];
    assign capLanes  = cfgByteEn[3:2];
    assign ctlLanes  = cfgByteEn[1:0];

    // ---------------------------------------------------------------
    // capability word
    // ---------------------------------------------------------------
    logic        capD3coldWake_r;
    logic        capD3coldWake_nxt;
    logic [15:0] capMerged;
    logic        capAuxBit;
    logic [15:0] capWord;

    // only bit 15 is writable; firmware writes zero without aux supply
    assign capMerged         = laneMerge(capWord, capWrWord, capLanes);
    assign capD3coldWake_nxt = capWr ? capMerged[CAP_D3COLD_BIT] : capD3coldWake_r;

    assign capAuxBit = CAP_AUX_REQUIRED & capD3coldWake_r;

    assign capWord = {capD3coldWake_r,
                      CAP_WAKE_LOW_MASK,
                      CAP_STATE2_SUP,
                      CAP_STATE1_SUP,
                      CAP_RSVD_VAL,
                      CAP_DSI_VAL,
                      capAuxBit,
                      CAP_WAKE_NEEDS_CLK,
                      CAP_VERSION};

    // global reset is the only reset of this bit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            capD3coldWake_r <= CAP_D3COLD_RST;
        end else if (clkEn) begin
            capD3coldWake_r <= capD3coldWake_nxt;
        end
    end

    // ---------------------------------------------------------------
    // control/status word writes
    // ---------------------------------------------------------------
    logic [15:0] ctlMerged;
    logic        statusClr;
    logic        enableWr;
    logic        stateWr;
    logic [1:0]  stateWrVal;
    logic        leaveD3hot;

    // reserved and data fields are not stored, so writes there vanish
    assign ctlMerged  = laneMerge(CTL_RST_VAL, ctlWrWord, ctlLanes);
    assign statusClr  = ctlWr & ctlLanes[1] & ctlWrWord[CTL_STATUS_BIT];
    assign enableWr   = ctlWr & ctlLanes[1];
    assign stateWr    = ctlWr & ctlLanes[0];
    assign stateWrVal = ctlMerged[CTL_STATE_LSB +: 2];
    assign leaveD3hot = stateWr & (powerStateField == PS_D3HOT) & (stateWrVal == PS_D0);

    // ---------------------------------------------------------------
    // wake logic
    // ---------------------------------------------------------------
    logic        wakeStatusFlag;
    logic        wakeEnableBit;

    pmr_wake_ctl u_wake_ctl (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .clkEn          (clkEn),
        .wakeEvent      (wakeEvent),
        .statusClr      (statusClr),
        .enableWr       (enableWr),
        .enableVal      (ctlMerged[CTL_ENABLE_BIT]),
        .wakeStatusFlag (wakeStatusFlag),
        .wakeEnableBit  (wakeEnableBit),
        .wakeOut_n      (wakeOut_n)
    );

    // ---------------------------------------------------------------
    // power state and internal function reset
    // ---------------------------------------------------------------
    pmr_state_t  fsmState_r;
    pmr_state_t  fsmState_nxt;
    logic [3:0]  rstCount_r;
    logic [3:0]  rstCount_nxt;
    logic [1:0]  powerState_nxt;
    logic        funcReset_nxt;
    logic        wakeCtxKeep_nxt;
    logic        rstDone;

    assign rstDone = (rstCount_r == 4'h1);

    // the bus reset returns to D0 but the internal pulse never touches this field
    assign powerState_nxt = busRstActive ? PS_D0 :
                            stateWr      ? stateWrVal : powerStateField;

    always_comb begin
        fsmState_nxt = fsmState_r;
        rstCount_nxt = rstCount_r;
        case (fsmState_r)
            PMR_RUN: begin
                if (leaveD3hot & ~busRstActive) begin
                    fsmState_nxt = PMR_FUNC_RST;
                    rstCount_nxt = FUNC_RST_CYCLES;
                end
            end
            PMR_FUNC_RST: begin
                if (rstDone) begin
                    fsmState_nxt = PMR_RUN;
                    rstCount_nxt = 4'h0;
                end else begin
                    rstCount_nxt = rstCount_r - 4'h1;
                end
            end
            default: begin
                fsmState_nxt = PMR_RUN;
                rstCount_nxt = 4'h0;
            end
        endcase
    end

    logic        enableNow;

    // an enable written in the same access as the D3hot exit already counts
    assign enableNow       = enableWr ? ctlMerged[CTL_ENABLE_BIT] : wakeEnableBit;
    assign funcReset_nxt   = (fsmState_nxt == PMR_FUNC_RST);
    // tells the function logic which wake context to preserve
    assign wakeCtxKeep_nxt = funcReset_nxt & enableNow;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fsmState_r      <= PMR_RUN;
            rstCount_r      <= 4'h0;
            powerStateField <= PS_D0;
            funcReset       <= 1'h0;
            wakeCtxKeep     <= 1'h0;
        end else if (clkEn) begin
            fsmState_r      <= fsmState_nxt;
            rstCount_r      <= rstCount_nxt;
            powerStateField <= powerState_nxt;
            funcReset       <= funcReset_nxt;
            wakeCtxKeep     <= wakeCtxKeep_nxt;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    logic [15:0] ctlWord;
    logic [31:0] rdMux;

    assign ctlWord = {wakeStatusFlag,
                      CTL_DATA_SCALE,
                      CTL_DATA_SELECT,
                      wakeEnableBit,
                      CTL_RSVD_VAL,
                      powerStateField};

    // list header and bridge extension bytes belong elsewhere and read zero here
    assign rdMux = capRd ? {capWord, 16'h0000} :
                   ctlRd ? {16'h0000, ctlWord} : 32'h0000_0000;

    // one-cycle answer; unmapped addresses answer with zero data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfgRdData  <= 32'h0000_0000;
            cfgRdValid <= 1'h0;
        end else if (clkEn) begin
            cfgRdData  <= rdMux;
            cfgRdValid <= cfgRdEn;
        end
    end

endmodule : pmr_regs
`default_nettype wire

// ==== pmr_regs_monitor.sv ====
// assertion checker for the power management register bank
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_monitor
    import pmr_pkg::*;
(
    // clock and resets
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        busReset_n,
    // configuration port
    input wire logic        cfgWrEn,
    input wire logic        cfgRdEn,
    input wire logic [7:0]  cfgAddr,
    input wire logic [3:0]  cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgRdValid,
    // wake and function control
    input wire logic        wakeEvent,
    input wire logic        wakeOut_n,
    input wire logic [1:0]  powerStateField,
    input wire logic        funcReset,
    input wire logic        wakeCtxKeep
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire capRd = cfgRdEn && clkEn && cfgAddr[7:2] == CAP_DW_ADDR[7:2];
    wire ctlRd = cfgRdEn && clkEn && cfgAddr[7:2] == CTL_DW_ADDR[7:2];
    wire ctlWr = cfgWrEn && clkEn && cfgAddr[7:2] == CTL_DW_ADDR[7:2];
    chk_caps_const: assert property (capRd |=> cfgRdValid
        && cfgRdData[30:21] == 10'h3F0 && cfgRdData[19:16] == 4'h2)
        else $error("capability constant bits wrong");
    chk_aux_gate: assert property (capRd |=> cfgRdData[20] == cfgRdData[31])
        else $error("aux bit does not follow cold-wake bit");
    chk_ctl_zeros: assert property (ctlRd |=> cfgRdValid
        && cfgRdData[14:9] == 6'h00 && cfgRdData[7:2] == 6'h00)
        else $error("control reserved bits not zero");
    chk_clear_release: assert property (ctlWr && cfgByteEn[1] && cfgWrData[15]
        && !wakeEvent && busReset_n && $past(busReset_n, 5) |=> wakeOut_n)
        else $error("wake not released by status clear");
    chk_wake_hold: assert property (!wakeOut_n && !ctlWr |=> !wakeOut_n)
        else $error("wake released without a clear");
    chk_wake_cause: assert property ($fell(wakeOut_n) |-> $past(wakeEvent || ctlWr))
        else $error("wake raised without event or enable write");
    chk_frst_len: assert property ($rose(funcReset) |-> funcReset[*8] ##1 !funcReset)
        else $error("function reset length wrong");
    chk_frst_cause: assert property ($rose(funcReset)
        |-> $past(powerStateField) == PS_D3HOT && powerStateField == PS_D0)
        else $error("function reset without leaving D3hot");
    chk_ctx_keep: assert property (wakeCtxKeep |-> funcReset)
        else $error("context keep outside function reset");
    chk_state_write: assert property (ctlWr && cfgByteEn[0] && busReset_n
        && $past(busReset_n, 5) |=> powerStateField == $past(cfgWrData[1:0]))
        else $error("power state write lost");
    chk_state_keep: assert property (funcReset && !cfgWrEn |=> $stable(powerStateField))
        else $error("state changed by internal reset");
    cov_frst: cover property ($rose(funcReset));
    cov_wake: cover property ($fell(wakeOut_n));
    cov_busrst_wr: cover property (ctlWr && !busReset_n);
endmodule : pmr_regs_monitor
bind pmr_regs pmr_regs_monitor mon_u (.ref_clk, .rst, .clkEn, .busReset_n, .cfgWrEn,
    .cfgRdEn, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .wakeEvent,
    .wakeOut_n, .powerStateField, .funcReset, .wakeCtxKeep);
`default_nettype wire

// ==== pmr_host_model.sv ====
// configuration host model driving the register bank access port
`timescale 1ns/100ps
`default_nettype none
module pmr_host_model (
    // clock
    input  wire logic        ref_clk,
    // request side
    output var  logic        cfgWrEn,
    output var  logic        cfgRdEn,
    output var  logic [7:0]  cfgAddr,
    output var  logic [3:0]  cfgByteEn,
    output var  logic [31:0] cfgWrData,
    // answer side
    input  wire logic [31:0] cfgRdData,
    input  wire logic        cfgRdValid
);
    initial begin
        cfgWrEn = 1'h0;
        cfgRdEn = 1'h0;
        cfgAddr = 8'h00;
        cfgByteEn = 4'h0;
        cfgWrData = 32'h0000_0000;
    end
    // idle lines toggle so a stale value is never read as a live request
    task automatic idle_lines;
        cfgAddr <= ~cfgAddr;
        cfgByteEn <= ~cfgByteEn;
        cfgWrData <= ~cfgWrData;
    endtask : idle_lines
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        cfgWrEn <= 1'h1;
        cfgAddr <= a;
        cfgByteEn <= be;
        cfgWrData <= d;
        @(posedge ref_clk);
        cfgWrEn <= 1'h0;
        idle_lines();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge ref_clk);
        cfgRdEn <= 1'h1;
        cfgAddr <= a;
        @(posedge ref_clk);
        cfgRdEn <= 1'h0;
        idle_lines();
        @(negedge ref_clk);
        d = cfgRdData;
        v = cfgRdValid;
    endtask : rd
endmodule : pmr_host_model
`default_nettype wire

// ==== pmr_regs_tb.sv ====
// self-checking bench for the power management register bank
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_tb;
    import pmr_pkg::*;
    logic        ref_clk;
    logic        rst;
    logic        clkEn;
    logic        busReset_n;
    logic        wakeEvent;
    logic        cfgWrEn;
    logic        cfgRdEn;
    logic [7:0]  cfgAddr;
    logic [3:0]  cfgByteEn;
    logic [31:0] cfgWrData;
    logic [31:0] cfgRdData;
    logic        cfgRdValid;
    logic        wakeOut_n;
    logic [1:0]  powerStateField;
    logic        funcReset;
    logic        wakeCtxKeep;
    logic [31:0] seed;
    logic        en;
    logic [1:0]  ps;
    int          errorCnt;
    int          checks;
    pmr_regs dut_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .busReset_n(busReset_n),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .wakeEvent(wakeEvent), .wakeOut_n(wakeOut_n), .powerStateField(powerStateField),
        .funcReset(funcReset), .wakeCtxKeep(wakeCtxKeep));
    pmr_host_model host_u (.ref_clk(ref_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [31:0] capExp(input logic b);
        return {b, 4'hF, 2'h3, 3'h0, 1'h0, b, 1'h0, 3'h2, 16'h0000};
    endfunction : capExp
    function automatic logic [31:0] ctlExp(input logic st, input logic e, input logic [1:0] p);
        return {16'h0000, st, 6'h00, e, 6'h00, p};
    endfunction : ctlExp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        host_u.rd(a, d, v);
        check({31'h0, v}, 32'h1);
        check(d, exp);
    endtask : rdchk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errorCnt++;
        tally_and_finish();
    end
    initial begin
        rst = 1'h1;
        clkEn = 1'h1;
        busReset_n = 1'h1;
        wakeEvent = 1'h0;
        seed = 32'h779B29E5;
        errorCnt = 0;
        checks = 0;
        en = 1'h0;
        ps = PS_D0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        rdchk(CAP_DW_ADDR, capExp(1'h1));
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h0, PS_D0));
        rdchk(8'hB0, 32'h0000_0000);
        host_u.wr(CAP_DW_ADDR, 4'hC, 32'h0000_0000);
        rdchk(CAP_DW_ADDR, capExp(1'h0));
        host_u.wr(CAP_DW_ADDR, 4'hC, 32'hFFFF_FFFF);
        rdchk(CAP_DW_ADDR, capExp(1'h1));
        $display("test capability done");
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            if (seed[17]) en = seed[8];
            if (seed[16]) ps = seed[1:0];
            host_u.wr(CTL_DW_ADDR, seed[19:16], seed);
            rdchk(CTL_DW_ADDR, ctlExp(1'h0, en, ps));
        end
        for (int s = 0; s < 4; s++) begin
            host_u.wr(CTL_DW_ADDR, 4'h1, 32'(s));
            rdchk(CTL_DW_ADDR, ctlExp(1'h0, en, 2'(s)));
            check({30'h0, powerStateField}, {30'h0, 2'(s)});
        end
        $display("test control fields done");
        // leaving D3hot with wake enabled: function reset, control word kept
        host_u.wr(CTL_DW_ADDR, 4'h3, 32'h0000_0100);
        @(negedge ref_clk);
        check({31'h0, funcReset}, 32'h1);
        check({31'h0, wakeCtxKeep}, 32'h1);
        repeat (10) @(posedge ref_clk);
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h1, PS_D0));
        $display("test d3hot exit done");
        host_u.wr(CTL_DW_ADDR, 4'h2, 32'h0000_0000);
        @(posedge ref_clk);
        wakeEvent <= 1'h1;
        @(posedge ref_clk);
        wakeEvent <= 1'h0;
        @(negedge ref_clk);
        check({31'h0, wakeOut_n}, 32'h1);
        rdchk(CTL_DW_ADDR, ctlExp(1'h1, 1'h0, PS_D0));
        host_u.wr(CTL_DW_ADDR, 4'h2, 32'h0000_0100);
        @(negedge ref_clk);
        check({31'h0, wakeOut_n}, 32'h0);
        host_u.wr(CTL_DW_ADDR, 4'h2, 32'h0000_0100);
        @(negedge ref_clk);
        check({31'h0, wakeOut_n}, 32'h0);
        host_u.wr(CTL_DW_ADDR, 4'h2, 32'h0000_8100);
        @(negedge ref_clk);
        check({31'h0, wakeOut_n}, 32'h1);
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h1, PS_D0));
        $display("test wake done");
        // a write taken while the clock enable is low must leave no trace
        @(posedge ref_clk);
        clkEn <= 1'h0;
        host_u.wr(CTL_DW_ADDR, 4'h3, 32'h0000_8003);
        clkEn <= 1'h1;
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h1, PS_D0));
        $display("test clock enable done");
        host_u.wr(CAP_DW_ADDR, 4'hC, 32'h0000_0000);
        host_u.wr(CTL_DW_ADDR, 4'h3, 32'h0000_0102);
        @(posedge ref_clk);
        busReset_n <= 1'h0;
        repeat (6) @(posedge ref_clk);
        host_u.wr(CTL_DW_ADDR, 4'h3, 32'h0000_0003);
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h1, PS_D0));
        rdchk(CAP_DW_ADDR, capExp(1'h0));
        @(posedge ref_clk);
        busReset_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h1, PS_D0));
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        rdchk(CAP_DW_ADDR, capExp(1'h1));
        rdchk(CTL_DW_ADDR, ctlExp(1'h0, 1'h0, PS_D0));
        $display("test resets done");
        tally_and_finish();
    end
endmodule : pmr_regs_tb
`default_nettype wire
